// File: quad_mode_pkg.sv
// Shared types and constants of the quad lane mode control block
package quad_mode_pkg;

    // Static control pins, in sync order
    typedef struct packed {
        logic       encode_select;
        logic       standby_enable;
        logic       chip_clear_n;
        logic       comma_align_enable;
        logic [1:0] direction_select;
        logic [3:0] serial_loop_enable;
        logic       pattern_test_enable;
        logic       lane_clock_share;
        logic       factory_test_strap;
    } strap_pins_t;

    // Level each pin takes when left open (pull-ups on the top four)
    localparam logic [12:0] PIN_DEFAULT = 13'h1E00;

    // Per-lane flags from the lane datapath
    typedef struct packed {
        logic no_input_signal_flag;
        logic comma_seen_flag;
        logic pattern_check_ok;
    } lane_status_t;

    typedef enum logic [1:0] {
        DIR_FULL    = 2'h0,
        DIR_TX_ONLY = 2'h1,
        DIR_RX_ONLY = 2'h2,
        DIR_REPEAT  = 2'h3
    } direction_mode_t;

    typedef enum logic [1:0] {
        IF_RAW_INDEP    = 2'h0,
        IF_RAW_SYNC     = 2'h1,
        IF_CODED_INDEP  = 2'h2,
        IF_EXT_SUBLAYER = 2'h3
    } interface_mode_t;

    typedef enum logic [1:0] {
        MF_IO_STD    = 2'h0,
        MF_NO_SIGNAL = 2'h1,
        MF_COMMA     = 2'h2,
        MF_PATTERN   = 2'h3
    } multi_func_t;

    typedef enum logic [1:0] {
        PH_IDLE  = 2'h0,
        PH_WRITE = 2'h1,
        PH_READ  = 2'h2
    } ahb_phase_t;

    // Register byte offsets
    localparam logic [7:0] OFS_CONTROL    = 8'h00;
    localparam logic [7:0] OFS_PIN_STATE  = 8'h04;
    localparam logic [7:0] OFS_IRQ_STATUS = 8'h08;
    localparam logic [7:0] OFS_IRQ_CLEAR  = 8'h0C;
    localparam logic [7:0] OFS_IRQ_ENABLE = 8'h10;
    localparam logic [7:0] OFS_LANE_STATE = 8'h14;
    localparam logic [7:0] OFS_UNMAPPED   = 8'hFC;

    // Control register: 2-bit function per lane, then output enable
    localparam int         CTRL_MF_EN_BIT = 8;
    localparam logic [8:0] CONTROL_RESET  = 9'h000;

    // Interrupt layout: loss rise, pattern fail, test strap seen
    localparam int         IRQ_LOS_LSB      = 0;
    localparam int         IRQ_FAIL_LSB     = 4;
    localparam int         IRQ_STRAP_BIT    = 8;
    localparam logic [8:0] IRQ_ENABLE_RESET = 9'h000;
    localparam logic [8:0] IRQ_STATUS_RESET = 9'h000;

    localparam logic       HRESP_OKAY = 1'b0;

endpackage

// File: pin_sync3.sv
// Three-stage synchroniser with agreement filter for static pins
`timescale 1ns/1ps
module pin_sync3 #(
    parameter int                WIDTH     = 13,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    // Clock and reset
    input  wire logic             i_sys_clk,
    input  wire logic             i_reset_n,
    // Pins in, filtered levels out
    input  wire logic [WIDTH-1:0] i_pins,
    output logic      [WIDTH-1:0] o_pins
);

    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
        logic [WIDTH-1:0] s3;
        logic [WIDTH-1:0] q;
    } sync_state_t;

    sync_state_t s;
    sync_state_t next_s;

    // Per bit: take the level only once stages two and three agree
    always_comb begin
        next_s    = s;
        next_s.s1 = i_pins;
        next_s.s2 = s.s1;
        next_s.s3 = s.s2;
        for (int b = 0; b < WIDTH; b++) begin
            if (s.s2[b] == s.s3[b]) begin
                next_s.q[b] = s.s3[b]; // RULE_16
            end
        end
    end

    // Reset to the open-pin levels
    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            s <= '{RESET_VAL, RESET_VAL, RESET_VAL, RESET_VAL}; // RULE_12
        end else begin
            s <= next_s;
        end
    end

    assign o_pins = s.q;

    // A filtered change always had two agreeing stages behind it
    sync_agree_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n) // RULE_16
        $changed(s.q) |-> ((s.q ^ $past(s.q)) & ($past(s.s2) ^ $past(s.s3))) == '0)
        else $error("filtered pin changed without agreement");

endmodule // pin_sync3

// File: lane_status_select.sv
// Per-lane multifunction output select and lane event detection
`timescale 1ns/1ps
module lane_status_select (
    // Clock and reset
    input  wire logic                       i_sys_clk,
    input  wire logic                       i_reset_n,
    // Lane flags and selection
    input  wire quad_mode_pkg::lane_status_t i_status,
    input  wire quad_mode_pkg::multi_func_t  i_func,
    input  wire logic                       i_out_enable,
    input  wire logic                       i_io_std_hstl,
    input  wire logic                       i_pattern_active,
    // Output pin and event pulses
    output logic                            o_multi_status,
    output logic                            o_los_rise,
    output logic                            o_pattern_fail
);

    typedef struct packed {
        logic mf;
        logic prev_los;
        logic prev_ok;
        logic los_rise;
        logic fail;
    } lane_state_t;

    lane_state_t s;
    lane_state_t next_s;

    // Until management enables the pin it only shows the I/O standard
    always_comb begin
        next_s          = s;
        next_s.prev_los = i_status.no_input_signal_flag;
        next_s.prev_ok  = i_status.pattern_check_ok;
        next_s.los_rise = i_status.no_input_signal_flag && !s.prev_los;
        next_s.fail     = i_pattern_active && s.prev_ok && !i_status.pattern_check_ok;
        next_s.mf       = i_io_std_hstl; // RULE_05
        if (i_out_enable) begin
            case (i_func)
                quad_mode_pkg::MF_NO_SIGNAL: next_s.mf = i_status.no_input_signal_flag;
                quad_mode_pkg::MF_COMMA:     next_s.mf = i_status.comma_seen_flag;
                quad_mode_pkg::MF_PATTERN:   next_s.mf = i_status.pattern_check_ok; // RULE_07
                default:                     next_s.mf = i_io_std_hstl;
            endcase
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign o_multi_status = s.mf;
    assign o_los_rise     = s.los_rise;
    assign o_pattern_fail = s.fail;

    // Pattern result never reaches the pin while outputs are disabled
    mf_gate_hold_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n) // RULE_07
        !i_out_enable |=> o_multi_status == $past(i_io_std_hstl))
        else $error("multifunction pin not gated by enable");

endmodule // lane_status_select

// File: quad_mode_control.sv
// Mode and test control for a four-lane serial transceiver
//
// Overview of operation
// RULE_01 - A high encode select turns on every lane's 8b/10b coding, low bypasses it.
// RULE_02 - The two direction select bits pick full, transmit only, receive only or repeater.
// RULE_03 - Standby enable low puts the device in low power, high resumes normal work.
// RULE_04 - A high loop enable folds that lane's serial output back into its own input.
// RULE_05 - Each lane's multifunction pin shows the managed choice, I/O standard by default.
// RULE_06 - Pattern test enable inserts a generator and a checker on every lane.
// RULE_07 - The pattern result reaches the multifunction pins only once management enables them.
// RULE_08 - With lane clock share high all lanes use lane A's transmit and receive clocks.
// RULE_09 - Chip clear low recenters the lane buffers and clears the management flags.
// RULE_10 - Comma align enable high turns on comma detection and alignment on all lanes.
// RULE_11 - The board keeps the factory test strap open or low in normal use.
// RULE_12 - Open pins read high for encode, standby, clear and comma align, low otherwise.
// RULE_13 - Encode select and lane clock share together pick one of four interface modes.
// RULE_14 - With lane clock share low every lane uses its own transmit and receive clocks.
// RULE_15 - With lane clock share high the transmit clocks of lanes B to D are ignored.
// RULE_16 - Every static pin is synchronised before any change acts.
// RULE_17 - Direction and clock share changes take effect only while chip clear is held.
//
// The AHB-Lite slave port and the register offsets were decided locally.
`timescale 1ns/1ps
module quad_mode_control (
    // Clock and reset
    input  wire logic                             i_sys_clk,
    input  wire logic                             i_reset_n,
    // AHB-Lite slave
    input  wire logic                             i_hsel,
    input  wire logic [31:0]                      i_haddr,
    input  wire logic [1:0]                       i_htrans,
    input  wire logic                             i_hwrite,
    input  wire logic [2:0]                       i_hsize,
    input  wire logic [31:0]                      i_hwdata,
    input  wire logic                             i_hready,
    output logic                                  o_hreadyout,
    output logic                                  o_hresp,
    output logic [31:0]                           o_hrdata,
    // Static control pins, asynchronous
    input  wire quad_mode_pkg::strap_pins_t       i_strap_pins,
    // Lane datapath flags, same clock
    input  wire quad_mode_pkg::lane_status_t [3:0] i_lane_status,
    input  wire logic                             i_io_std_hstl,
    // Mode controls to the lanes
    output logic                                  o_encode_enable,
    output quad_mode_pkg::direction_mode_t        o_direction_mode,
    output quad_mode_pkg::interface_mode_t        o_interface_mode,
    output logic                                  o_low_power,
    output logic [3:0]                            o_serial_loop,
    output logic                                  o_pattern_gen_enable,
    output logic                                  o_pattern_chk_enable,
    output logic                                  o_comma_align,
    output logic                                  o_lane_clock_share,
    output logic [3:0]                            o_tx_own_clock,
    output logic                                  o_fifo_recenter,
    // Status pins and interrupt
    output logic [3:0]                            o_lane_multi_status_out,
    output logic                                  o_irq
);

    typedef struct packed {
        quad_mode_pkg::ahb_phase_t      phase;
        logic [7:0]                     addr;
        logic                           hreadyout;
        logic [31:0]                    hrdata;
        logic [8:0]                     control;
        logic [8:0]                     irq_status;
        logic [8:0]                     irq_enable;
        logic                           irq;
        logic                           strap_prev;
        logic                           encode;
        logic                           low_power;
        logic [3:0]                     loop;
        logic                           pattern;
        logic                           comma;
        logic                           recenter;
        quad_mode_pkg::direction_mode_t dir;
        logic                           share;
        quad_mode_pkg::interface_mode_t if_mode;
        logic [3:0]                     tx_own;
    } ctrl_state_t;

    // Reset matches the open-pin levels so outputs agree with synced pins
    localparam ctrl_state_t STATE_RESET = '{
        phase:      quad_mode_pkg::PH_IDLE,
        addr:       8'h00,
        hreadyout:  1'b1,
        hrdata:     32'h0000_0000,
        control:    quad_mode_pkg::CONTROL_RESET,
        irq_status: quad_mode_pkg::IRQ_STATUS_RESET,
        irq_enable: quad_mode_pkg::IRQ_ENABLE_RESET,
        irq:        1'b0,
        strap_prev: 1'b0,
        encode:     1'b1,
        low_power:  1'b0,
        loop:       4'h0,
        pattern:    1'b0,
        comma:      1'b1,
        recenter:   1'b0,
        dir:        quad_mode_pkg::DIR_FULL,
        share:      1'b0,
        if_mode:    quad_mode_pkg::IF_CODED_INDEP,
        tx_own:     4'hF
    };

    ctrl_state_t                s;
    ctrl_state_t                next_s;
    quad_mode_pkg::strap_pins_t pins;
    logic [3:0]                 los_rise;
    logic [3:0]                 pattern_fail;
    logic                       addr_phase;

    // Pins arrive from the board, so filter them first
    pin_sync3 #(
        .WIDTH     (13),
        .RESET_VAL (quad_mode_pkg::PIN_DEFAULT)
    ) u_pin_sync (
        .i_sys_clk (i_sys_clk),
        .i_reset_n (i_reset_n),
        .i_pins    (i_strap_pins),
        .o_pins    (pins)
    );

    // One output selector per lane
    for (genvar g = 0; g < 4; g++) begin : g_lane
        lane_status_select u_lane (
            .i_sys_clk        (i_sys_clk),
            .i_reset_n        (i_reset_n),
            .i_status         (i_lane_status[g]),
            .i_func           (quad_mode_pkg::multi_func_t'(s.control[2*g +: 2])),
            .i_out_enable     (s.control[quad_mode_pkg::CTRL_MF_EN_BIT]),
            .i_io_std_hstl    (i_io_std_hstl),
            .i_pattern_active (s.pattern),
            .o_multi_status   (o_lane_multi_status_out[g]),
            .o_los_rise       (los_rise[g]),
            .o_pattern_fail   (pattern_fail[g])
        );
    end

    // Whole-word single transfers only, so size is not decoded
    assign addr_phase = i_hsel && i_hready && i_htrans[1];

    // Bus slave, interrupt flags and mode decode
    always_comb begin
        logic [8:0] events;
        logic [8:0] clear_mask;
        events     = '0;
        clear_mask = '0;
        next_s     = s;

        // Data phase of a write: lands at the edge closing it
        if (s.phase == quad_mode_pkg::PH_WRITE) begin
            case (s.addr)
                quad_mode_pkg::OFS_CONTROL:    next_s.control    = i_hwdata[8:0];
                quad_mode_pkg::OFS_IRQ_ENABLE: next_s.irq_enable = i_hwdata[8:0];
                quad_mode_pkg::OFS_IRQ_CLEAR:  clear_mask        = i_hwdata[8:0];
                default:                       clear_mask        = '0;
            endcase
            next_s.phase = quad_mode_pkg::PH_IDLE;
        end

        // Read wait state over: data and ready go out together
        if (s.phase == quad_mode_pkg::PH_READ) begin
            case (s.addr)
                quad_mode_pkg::OFS_CONTROL:    next_s.hrdata = {23'h0, s.control};
                quad_mode_pkg::OFS_PIN_STATE:  next_s.hrdata = {19'h0, pins};
                quad_mode_pkg::OFS_IRQ_STATUS: next_s.hrdata = {23'h0, s.irq_status};
                quad_mode_pkg::OFS_IRQ_ENABLE: next_s.hrdata = {23'h0, s.irq_enable};
                quad_mode_pkg::OFS_LANE_STATE: next_s.hrdata = {20'h0, i_lane_status};
                default:                       next_s.hrdata = 32'h0000_0000;
            endcase
            next_s.hreadyout = 1'b1;
            next_s.phase     = quad_mode_pkg::PH_IDLE;
        end

        // New address phase; upper address bits must be zero to hit
        if (addr_phase) begin
            next_s.addr = (|i_haddr[31:8]) ? quad_mode_pkg::OFS_UNMAPPED : i_haddr[7:0];
            if (i_hwrite) begin
                next_s.phase = quad_mode_pkg::PH_WRITE;
            end else begin
                next_s.phase     = quad_mode_pkg::PH_READ;
                next_s.hreadyout = 1'b0;
            end
        end

        // Sticky events; a set in the clear cycle survives
        events[quad_mode_pkg::IRQ_LOS_LSB +: 4]  = los_rise;
        events[quad_mode_pkg::IRQ_FAIL_LSB +: 4] = pattern_fail;
        events[quad_mode_pkg::IRQ_STRAP_BIT]     = pins.factory_test_strap && !s.strap_prev;
        next_s.strap_prev = pins.factory_test_strap;
        next_s.irq_status = (s.irq_status & ~clear_mask) | events;

        // Chip clear wipes the management flags and recenters the FIFOs
        next_s.recenter = !pins.chip_clear_n; // RULE_09
        if (!pins.chip_clear_n) begin
            next_s.irq_status = quad_mode_pkg::IRQ_STATUS_RESET; // RULE_09
            // Mode swaps only here, so FIFOs never restart mid-stream
            next_s.dir   = quad_mode_pkg::direction_mode_t'(pins.direction_select); // RULE_02 RULE_17
            next_s.share = pins.lane_clock_share; // RULE_17
        end
        next_s.irq = |(next_s.irq_status & next_s.irq_enable);

        // Static controls follow the filtered pins
        next_s.encode    = pins.encode_select; // RULE_01
        next_s.low_power = !pins.standby_enable; // RULE_03
        next_s.loop      = pins.serial_loop_enable; // RULE_04
        next_s.pattern   = pins.pattern_test_enable; // RULE_06
        next_s.comma     = pins.comma_align_enable; // RULE_10

        // Shared clocking leaves only lane A on its own clock
        next_s.tx_own  = next_s.share ? 4'h1 : 4'hF; // RULE_08 RULE_14 RULE_15
        next_s.if_mode = quad_mode_pkg::interface_mode_t'({next_s.encode, next_s.share}); // RULE_13
    end

    // Single state register
    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            s <= STATE_RESET;
        end else begin
            s <= next_s;
        end
    end

    // Outputs straight from the state register, except o_hresp tied to OKAY
    assign o_hreadyout          = s.hreadyout;
    assign o_hresp              = quad_mode_pkg::HRESP_OKAY;
    assign o_hrdata             = s.hrdata;
    assign o_encode_enable      = s.encode;
    assign o_direction_mode     = s.dir;
    assign o_interface_mode     = s.if_mode;
    assign o_low_power          = s.low_power;
    assign o_serial_loop        = s.loop;
    assign o_pattern_gen_enable = s.pattern;
    assign o_pattern_chk_enable = s.pattern;
    assign o_comma_align        = s.comma;
    assign o_lane_clock_share   = s.share;
    assign o_tx_own_clock       = s.tx_own;
    assign o_fifo_recenter      = s.recenter;
    assign o_irq                = s.irq;

    // Checks on the control outputs
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_reset_n);

    sequence rd_addr_s;
        i_hsel && i_hready && i_htrans[1] && !i_hwrite && (s.phase != quad_mode_pkg::PH_READ);
    endsequence

    sequence rd_done_s;
        !o_hreadyout ##1 o_hreadyout;
    endsequence

    sequence clear_held_s;
        !pins.chip_clear_n;
    endsequence

    read_wait_once_a: assert property (rd_addr_s |=> rd_done_s)
        else $error("read did not take exactly one wait state");

    encode_follow_a: assert property ( // RULE_01
        ##1 o_encode_enable == $past(pins.encode_select))
        else $error("encode enable does not follow pin");

    dir_apply_a: assert property ( // RULE_02
        clear_held_s |=> o_direction_mode == $past(pins.direction_select))
        else $error("direction mode not taken during clear");

    mode_frozen_a: assert property ( // RULE_17
        pins.chip_clear_n && $past(pins.chip_clear_n) |=> $stable(o_direction_mode)
        && $stable(o_lane_clock_share))
        else $error("mode changed outside chip clear");

    standby_power_a: assert property ( // RULE_03
        ##1 o_low_power == !$past(pins.standby_enable))
        else $error("low power does not track standby pin");

    loop_route_a: assert property ( // RULE_04
        ##1 o_serial_loop == $past(pins.serial_loop_enable))
        else $error("loop enables do not follow pins");

    pattern_insert_a: assert property ( // RULE_06
        pins.pattern_test_enable |=> o_pattern_gen_enable && o_pattern_chk_enable)
        else $error("pattern test not inserted");

    shared_clock_a: assert property ( // RULE_08
        o_lane_clock_share |-> o_tx_own_clock == 4'h1)
        else $error("shared clocking still uses lane clocks");

    own_clock_a: assert property ( // RULE_14
        !o_lane_clock_share |-> o_tx_own_clock == 4'hF)
        else $error("independent lanes not on own clocks");

    clear_recenter_a: assert property ( // RULE_09
        clear_held_s |=> o_fifo_recenter && s.irq_status == 9'h000 && !o_irq)
        else $error("chip clear did not recenter and clear flags");

    comma_follow_a: assert property ( // RULE_10
        ##1 o_comma_align == $past(pins.comma_align_enable))
        else $error("comma align does not follow pin");

    mode_map_a: assert property ( // RULE_13
        o_interface_mode == {o_encode_enable, o_lane_clock_share})
        else $error("interface mode decode wrong");

    irq_level_a: assert property (
        ##1 o_irq == |($past(next_s.irq_status) & $past(next_s.irq_enable)))
        else $error("interrupt level mismatch");

endmodule // quad_mode_control

// File: board_strap_model.sv
// Board strapping and lane flag model that drives the control block's pins
`timescale 1ns/1ps
module board_strap_model (
    // Clock
    input  wire logic                              i_sys_clk,
    // Levels requested by the bench
    input  wire quad_mode_pkg::strap_pins_t        i_strap_req,
    input  wire quad_mode_pkg::lane_status_t [3:0] i_lane_req,
    input  wire logic                              i_strap_fault,
    // Board pins
    output quad_mode_pkg::strap_pins_t             o_strap_pins,
    output quad_mode_pkg::lane_status_t [3:0]      o_lane_status
);
    // Pins move just after an edge; the test strap stays low unless a fault is ordered
    always @(posedge i_sys_clk) begin
        o_strap_pins <= {i_strap_req[12:1], i_strap_fault};
        o_lane_status <= i_lane_req;
    end
endmodule // board_strap_model

// File: quad_mode_control_tb.sv
// Self-checking bench for the quad lane mode control block
`timescale 1ns/1ps
module quad_mode_control_tb;
    logic                              sys_clk = 1'b0, reset_n = 1'b0, hsel = 1'b0;
    logic                              hwrite = 1'b0, hstl = 1'b1, fault = 1'b0;
    logic [1:0]                        htrans = 2'h0;
    logic [31:0]                       haddr = 32'h0, hwdata = 32'h0, rd, hrdata;
    quad_mode_pkg::strap_pins_t        req = quad_mode_pkg::PIN_DEFAULT, pins;
    quad_mode_pkg::lane_status_t [3:0] lreq = '0, lanes;
    logic                              hready, hresp, enc, lowp, gen, chk, comma, share;
    logic                              recenter, irq;
    logic [3:0]                        loop, own, mstat;
    quad_mode_pkg::direction_mode_t    dir;
    quad_mode_pkg::interface_mode_t    ifm;
    int                                num_errors = 0, comparisons = 0;

    // 250 MHz clock
    always #2 sys_clk = ~sys_clk;

    board_strap_model u_board (.i_sys_clk(sys_clk), .i_strap_req(req), .i_lane_req(lreq),
        .i_strap_fault(fault), .o_strap_pins(pins), .o_lane_status(lanes));

    quad_mode_control u_dut (
        .i_sys_clk(sys_clk), .i_reset_n(reset_n), .i_hsel(hsel), .i_haddr(haddr),
        .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata),
        .i_hready(hready), .o_hreadyout(hready), .o_hresp(hresp), .o_hrdata(hrdata),
        .i_strap_pins(pins), .i_lane_status(lanes), .i_io_std_hstl(hstl),
        .o_encode_enable(enc), .o_direction_mode(dir), .o_interface_mode(ifm),
        .o_low_power(lowp), .o_serial_loop(loop), .o_pattern_gen_enable(gen),
        .o_pattern_chk_enable(chk), .o_comma_align(comma), .o_lane_clock_share(share),
        .o_tx_own_clock(own), .o_fifo_recenter(recenter), .o_lane_multi_status_out(mstat),
        .o_irq(irq));

    // Compare and count
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask

    task automatic wrap_up;
        $display("errors %0d, comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // Bounded wait for hready, so a stuck slave ends the run
    task automatic wait_ready;
        int n;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (hready !== 1'b1 && n < 50);
        if (hready !== 1'b1) begin
            num_errors++;
            $display("unexpected at %0t: bus hang", $time);
            wrap_up();
        end
    endtask

    // One single word transfer; read data lands in rd
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= wr;
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_ready();
        rd = hrdata;
    endtask

    // Pins need four edges through the filter plus the board and state registers
    task automatic settle;
        repeat (8) @(posedge sys_clk);
    endtask

    initial begin
        repeat (20) @(posedge sys_clk);
        reset_n <= 1'b1;
        settle();
        check({enc, lowp, comma, dir, own, ifm}, {5'h14, 4'hF, 2'h2});
        bus(1'b0, quad_mode_pkg::OFS_PIN_STATE, '0);
        check(rd, 32'h1E00);
        // Every direction mode, clock sharing on odd ones, applied under chip clear
        for (int m = 0; m < 4; m++) begin
            req.chip_clear_n <= 1'b0;
            req.direction_select <= m[1:0];
            req.lane_clock_share <= m[0];
            settle();
            check(recenter, 1'b1);
            req.chip_clear_n <= 1'b1;
            settle();
            check({dir, share, own, ifm}, {m[1:0], m[0], m[0] ? 4'h1 : 4'hF, 1'b1, m[0]});
        end
        // Mode change with clear released must be ignored
        req.direction_select <= 2'h0;
        req.lane_clock_share <= 1'b0;
        settle();
        check({dir, share}, 3'h7);
        req.encode_select <= 1'b0;
        req.standby_enable <= 1'b0;
        req.comma_align_enable <= 1'b0;
        req.serial_loop_enable <= 4'hA;
        req.pattern_test_enable <= 1'b1;
        settle();
        check({enc, lowp, comma, loop, gen, chk, ifm}, {7'h2A, 4'hD});
        // Multifunction pins: select per lane, enable bit gates them
        lreq[1].no_input_signal_flag <= 1'b1;
        lreq[2].comma_seen_flag <= 1'b1;
        lreq[3].pattern_check_ok <= 1'b1;
        bus(1'b1, quad_mode_pkg::OFS_CONTROL, 32'h0E4);
        settle();
        check(mstat, 4'hF);
        hstl <= 1'b0;
        bus(1'b1, quad_mode_pkg::OFS_CONTROL, 32'h1E4);
        settle();
        check(mstat, 4'hE);
        lreq[2].comma_seen_flag <= 1'b0;
        settle();
        check(mstat, 4'hA);
        // Interrupt raised by the loss event, cleared, then strap event wiped by chip clear
        bus(1'b1, quad_mode_pkg::OFS_IRQ_ENABLE, 32'h1FF);
        settle();
        check(irq, 1'b1);
        bus(1'b0, quad_mode_pkg::OFS_IRQ_ENABLE, '0);
        check(rd, 32'h1FF);
        bus(1'b0, quad_mode_pkg::OFS_LANE_STATE, '0);
        check(rd, 32'h220);
        bus(1'b0, quad_mode_pkg::OFS_IRQ_STATUS, '0);
        check(rd, 32'h2);
        bus(1'b1, quad_mode_pkg::OFS_IRQ_CLEAR, 32'h2);
        settle();
        check(irq, 1'b0);
        fault <= 1'b1;
        settle();
        bus(1'b0, quad_mode_pkg::OFS_IRQ_STATUS, '0);
        check(rd, 32'h100);
        req.chip_clear_n <= 1'b0;
        settle();
        bus(1'b0, quad_mode_pkg::OFS_IRQ_STATUS, '0);
        check({rd[8:0], irq}, 10'h0);
        bus(1'b0, quad_mode_pkg::OFS_UNMAPPED, '0);
        check({rd, hresp}, 33'h0);
        wrap_up();
    end
endmodule // quad_mode_control_tb
